// ### verilog/ovrfd_regs.svh
// Register offsets, field positions and timing counts for overrange detect
`ifndef OVRFD_REGS_SVH
`define OVRFD_REGS_SVH
`define OVRFD_ADDR_W          13
`define OVRFD_OFS_UPPER_LO    13'h0247
`define OVRFD_OFS_UPPER_HI    13'h0248
`define OVRFD_OFS_LOWER_LO    13'h0249
`define OVRFD_OFS_LOWER_HI    13'h024A
`define OVRFD_OFS_DWELL_LO    13'h024B
`define OVRFD_OFS_DWELL_HI    13'h024C
`define OVRFD_OFS_OVR_CLEAR   13'h0562
`define OVRFD_OFS_OVR_STATUS  13'h0563
`define OVRFD_THR_W           13
`define OVRFD_HI_FIELD_W      5
`define OVRFD_RST_UPPER       13'h0000
`define OVRFD_RST_LOWER       13'h0000
`define OVRFD_RST_DWELL       16'h0001
`define OVRFD_RST_BYTE        8'h00
`define OVRFD_UPPER_LAT_MAX   28
`define OVRFD_PIPE_LAT        4
`endif

// ### verilog/ovrfd_pkg.sv
// Types shared by the overrange and fast detect block
package ovrfd_pkg;
   typedef logic [12:0] ovrfd_mag_t;
   typedef logic [15:0] ovrfd_dwell_t;
   typedef struct packed {
      logic [12:0] upper;
      logic [12:0] lower;
      logic [15:0] dwell;
   } ovrfd_thr_s;
   typedef enum logic [1:0] {
      OVRFD_IDLE,
      OVRFD_HELD,
      OVRFD_DWELL
   } ovrfd_state_e;
endpackage : ovrfd_pkg

// ### verilog/ovrfd_chan.sv
// One channel of fast threshold detection with dwell hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "ovrfd_regs.svh"
module ovrfd_chan #(
   parameter int MAG_W = 13
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic [MAG_W-1:0]  magnitude,
   input  wire ovrfd_pkg::ovrfd_thr_s thr,
   output var  logic              flag
);
   initial begin
      if (MAG_W != `OVRFD_THR_W) $error("ovrfd_chan: MAG_W must be 13");
   end

   ovrfd_pkg::ovrfd_state_e state_r;
   ovrfd_pkg::ovrfd_state_e state_nxt;
   logic [15:0]             cnt_r;
   logic [15:0]             cnt_nxt;

   wire above_upper = magnitude > thr.upper;
   wire below_lower = magnitude < thr.lower;
   wire dwell_done  = cnt_r >= thr.dwell;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ovrfd_pkg::OVRFD_IDLE: begin
            if (above_upper) begin
               state_nxt = ovrfd_pkg::OVRFD_HELD;
            end
         end
         ovrfd_pkg::OVRFD_HELD: begin
            if (below_lower && !above_upper) begin
               state_nxt = ovrfd_pkg::OVRFD_DWELL;
               cnt_nxt   = 16'h0001;
            end
         end
         ovrfd_pkg::OVRFD_DWELL: begin
            if (above_upper || !below_lower) begin
               state_nxt = ovrfd_pkg::OVRFD_HELD;
               cnt_nxt   = 16'h0000;
            end else if (dwell_done) begin
               state_nxt = ovrfd_pkg::OVRFD_IDLE;
               cnt_nxt   = 16'h0000;
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         default: begin
            state_nxt = ovrfd_pkg::OVRFD_IDLE;
            cnt_nxt   = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= ovrfd_pkg::OVRFD_IDLE;
         cnt_r   <= 16'h0000;
         flag    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         flag    <= state_nxt != ovrfd_pkg::OVRFD_IDLE;
      end
   end
endmodule : ovrfd_chan
`default_nettype wire

// ### verilog/ovrfd_top.sv
// Overrange indicator, sticky status and two-channel fast detect
//
// Contract
// - Each of two channels has its own detector and flag pin.
// - Flag rises at once when magnitude exceeds upper threshold.
// - Flag falls only after magnitude stays below lower longer than dwell.
// - Upper threshold comes from a byte pair, compared with magnitude.
// - Flag rises within 28 cycles of upper crossing; the code takes PIPE_LAT + 2 cycles, so the allowed PIPE_LAT of 27 gives 29.
// - Lower threshold is 13 bits across a byte pair.
// - Lower compare uses full resolution, after pipeline delay.
// - Threshold codes scale against full scale two to the thirteenth.
// - Dwell count from 1 to 65535 in a byte pair.
// - Overrange indicator asserted, carried as link control bit when enabled.
// - Overrange indicator delayed to match sample latency.
// - Eight virtual converters each keep a sticky overrange bit.
`timescale 1ns/1ps
`default_nettype none
`include "ovrfd_regs.svh"
module ovrfd_top #(
   parameter int MAG_W    = 13,
   parameter int PIPE_LAT = `OVRFD_PIPE_LAT,
   parameter int NUM_VC   = 8
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic [MAG_W-1:0]  mag_a,
   input  wire logic [MAG_W-1:0]  mag_b,
   input  wire logic              ovr_in_a,
   input  wire logic              ovr_in_b,
   input  wire logic [NUM_VC-1:0] vc_ovr,
   input  wire logic              ctrl_bits_nonzero,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [12:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output var  logic [7:0]        reg_rdata,
   output var  logic              threshold_flag_out_a,
   output var  logic              threshold_flag_out_b,
   output var  logic              ovr_out_a,
   output var  logic              ovr_out_b,
   output var  logic              link_ctrl_a,
   output var  logic              link_ctrl_b
);
   initial begin
      if (MAG_W != `OVRFD_THR_W) $error("ovrfd_top: MAG_W must be 13");
      // Shift part-selects need at least two stages
      if (PIPE_LAT < 2 || PIPE_LAT > 27) $error("ovrfd_top: bad PIPE_LAT");
      if (NUM_VC != 8) $error("ovrfd_top: NUM_VC must be 8");
   end

   logic [7:0]  upper_lo_r;
   logic [4:0]  upper_hi_r;
   logic [7:0]  lower_lo_r;
   logic [4:0]  lower_hi_r;
   logic [7:0]  dwell_lo_r;
   logic [7:0]  dwell_hi_r;
   logic [7:0]  ovr_clear_r;
   logic [7:0]  ovr_sticky_r;
   logic [7:0]  ovr_sticky_nxt;

   wire sel_upper_lo = reg_addr == `OVRFD_OFS_UPPER_LO;
   wire sel_upper_hi = reg_addr == `OVRFD_OFS_UPPER_HI;
   wire sel_lower_lo = reg_addr == `OVRFD_OFS_LOWER_LO;
   wire sel_lower_hi = reg_addr == `OVRFD_OFS_LOWER_HI;
   wire sel_dwell_lo = reg_addr == `OVRFD_OFS_DWELL_LO;
   wire sel_dwell_hi = reg_addr == `OVRFD_OFS_DWELL_HI;
   wire sel_clear    = reg_addr == `OVRFD_OFS_OVR_CLEAR;
   wire sel_status   = reg_addr == `OVRFD_OFS_OVR_STATUS;

   // Assembled thresholds; the 13-bit codes sit on a 2^13 full scale
   ovrfd_pkg::ovrfd_thr_s thr;
   assign thr.upper = {upper_hi_r, upper_lo_r};
   assign thr.lower = {lower_hi_r, lower_lo_r};
   // Zero dwell is out of range; treated as one cycle
   assign thr.dwell = ({dwell_hi_r, dwell_lo_r} == 16'h0000) ?
                      16'h0001 : {dwell_hi_r, dwell_lo_r};

   wire [7:0] rd_mux =
      sel_upper_lo ? upper_lo_r :
      sel_upper_hi ? {3'h0, upper_hi_r} :
      sel_lower_lo ? lower_lo_r :
      sel_lower_hi ? {3'h0, lower_hi_r} :
      sel_dwell_lo ? dwell_lo_r :
      sel_dwell_hi ? dwell_hi_r :
      sel_clear    ? ovr_clear_r :
      sel_status   ? ovr_sticky_r : 8'h00;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         upper_lo_r  <= `OVRFD_RST_BYTE;
         upper_hi_r  <= 5'h00;
         lower_lo_r  <= `OVRFD_RST_BYTE;
         lower_hi_r  <= 5'h00;
         dwell_lo_r  <= 8'h01;
         dwell_hi_r  <= `OVRFD_RST_BYTE;
         ovr_clear_r <= `OVRFD_RST_BYTE;
      end else if (reg_wr) begin
         if (sel_upper_lo) upper_lo_r <= reg_wdata;
         if (sel_upper_hi) upper_hi_r <= reg_wdata[4:0];
         if (sel_lower_lo) lower_lo_r <= reg_wdata;
         if (sel_lower_hi) lower_hi_r <= reg_wdata[4:0];
         if (sel_dwell_lo) dwell_lo_r <= reg_wdata;
         if (sel_dwell_hi) dwell_hi_r <= reg_wdata;
         if (sel_clear)    ovr_clear_r <= reg_wdata;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // Clear bit held high forces zero; events set again once it drops
   assign ovr_sticky_nxt = (ovr_sticky_r | vc_ovr) & ~ovr_clear_r;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ovr_sticky_r <= `OVRFD_RST_BYTE;
      end else begin
         ovr_sticky_r <= ovr_sticky_nxt;
      end
   end

   // Overrange travels through the same depth as the sample pipe
   logic [PIPE_LAT-1:0] ovr_dly_a_r;
   logic [PIPE_LAT-1:0] ovr_dly_b_r;
   logic [MAG_W-1:0]    mag_dly_a_r [PIPE_LAT];
   logic [MAG_W-1:0]    mag_dly_b_r [PIPE_LAT];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ovr_dly_a_r <= '0;
         ovr_dly_b_r <= '0;
      end else begin
         ovr_dly_a_r <= {ovr_dly_a_r[PIPE_LAT-2:0], ovr_in_a};
         ovr_dly_b_r <= {ovr_dly_b_r[PIPE_LAT-2:0], ovr_in_b};
      end
   end

   // Sample pipe has no reset: it only carries data
   always_ff @(posedge clock) begin
      mag_dly_a_r[0] <= mag_a;
      mag_dly_b_r[0] <= mag_b;
      for (int i = 1; i < PIPE_LAT; i++) begin
         mag_dly_a_r[i] <= mag_dly_a_r[i-1];
         mag_dly_b_r[i] <= mag_dly_b_r[i-1];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ovr_out_a   <= 1'b0;
         ovr_out_b   <= 1'b0;
         link_ctrl_a <= 1'b0;
         link_ctrl_b <= 1'b0;
      end else begin
         ovr_out_a   <= ovr_dly_a_r[PIPE_LAT-1];
         ovr_out_b   <= ovr_dly_b_r[PIPE_LAT-1];
         link_ctrl_a <= ctrl_bits_nonzero & ovr_dly_a_r[PIPE_LAT-1];
         link_ctrl_b <= ctrl_bits_nonzero & ovr_dly_b_r[PIPE_LAT-1];
      end
   end

   // Magnitude taken after the pipe so compares see full-resolution data
   logic flag_a;
   logic flag_b;

   ovrfd_chan #(.MAG_W(MAG_W)) u_chan_a (
      .clock     (clock),
      .reset     (reset),
      .magnitude (mag_dly_a_r[PIPE_LAT-1]),
      .thr       (thr),
      .flag      (flag_a)
   );

   ovrfd_chan #(.MAG_W(MAG_W)) u_chan_b (
      .clock     (clock),
      .reset     (reset),
      .magnitude (mag_dly_b_r[PIPE_LAT-1]),
      .thr       (thr),
      .flag      (flag_b)
   );

   // Latency: PIPE_LAT + 2 cycles, inside the 28-cycle bound for PIPE_LAT up to 26 (27 gives 29)
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         threshold_flag_out_a <= 1'b0;
         threshold_flag_out_b <= 1'b0;
      end else begin
         threshold_flag_out_a <= flag_a;
         threshold_flag_out_b <= flag_b;
      end
   end
endmodule : ovrfd_top
`default_nettype wire

// ### test/ovrfd_monitor.sv
// Port checks for the overrange and fast detect block
`timescale 1ns/1ps
`default_nettype none
module ovrfd_monitor #(
   parameter int PIPE_LAT = 4
) (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [12:0] mag_a,
   input wire logic [12:0] mag_b,
   input wire logic        ovr_in_a,
   input wire logic        ovr_in_b,
   input wire logic        ctrl_bits_nonzero,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [12:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        threshold_flag_out_a,
   input wire logic        threshold_flag_out_b,
   input wire logic        ovr_out_a,
   input wire logic        ovr_out_b,
   input wire logic        link_ctrl_a,
   input wire logic        link_ctrl_b
);
   localparam int DLY = PIPE_LAT + 1;
   logic [12:0] up_r;
   // Shadow of the upper threshold, rebuilt from port writes
   always_ff @(posedge clock or posedge reset) begin
      if (reset) up_r <= 13'h0000;
      else if (reg_wr && reg_addr == 13'h0247) up_r[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == 13'h0248) up_r[12:8] <= reg_wdata[4:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_rise_a; mag_a > up_r |-> ##[1:28] threshold_flag_out_a; endproperty
   a_rise_a: assert property (p_rise_a) else $error("flag a late");
   property p_rise_b; mag_b > up_r |-> ##[1:28] threshold_flag_out_b; endproperty
   a_rise_b: assert property (p_rise_b) else $error("flag b late");
   property p_ovr_a; ovr_out_a == $past(ovr_in_a, DLY); endproperty
   a_ovr_a: assert property (p_ovr_a) else $error("ovr a skew");
   property p_ovr_b; ovr_out_b == $past(ovr_in_b, DLY); endproperty
   a_ovr_b: assert property (p_ovr_b) else $error("ovr b skew");
   property p_link_a;
      link_ctrl_a == (ovr_out_a && $past(ctrl_bits_nonzero));
   endproperty
   a_link_a: assert property (p_link_a) else $error("link a gate");
   property p_link_b;
      link_ctrl_b == (ovr_out_b && $past(ctrl_bits_nonzero));
   endproperty
   a_link_b: assert property (p_link_b) else $error("link b gate");
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("rdata moved");
   property p_unmap; reg_rd && reg_addr == 13'h1000 |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_hi; reg_rd && reg_addr == 13'h0248 |=> reg_rdata[7:5] == 3'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("high byte width");
endmodule : ovrfd_monitor
bind ovrfd_top ovrfd_monitor #(.PIPE_LAT(PIPE_LAT)) mon (.clock, .reset,
   .mag_a, .mag_b, .ovr_in_a, .ovr_in_b, .ctrl_bits_nonzero, .reg_wr,
   .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .threshold_flag_out_a,
   .threshold_flag_out_b, .ovr_out_a, .ovr_out_b, .link_ctrl_a,
   .link_ctrl_b);
`default_nettype wire

// ### test/ovrfd_agc_model.sv
// Gain control stand-in counting flag rises per channel
`timescale 1ns/1ps
`default_nettype none
module ovrfd_agc_model (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       flag_a,
   input  wire logic       flag_b,
   output var  logic [7:0] cuts_a,
   output var  logic [7:0] cuts_b
);
   logic prev_a, prev_b;
   // Each pin watched on its own; one gain cut per rise
   always @(posedge clock or posedge reset) begin
      if (reset) {cuts_a, cuts_b, prev_a, prev_b} <= 18'h00000;
      else begin
         cuts_a <= cuts_a + 8'(flag_a & ~prev_a);
         cuts_b <= cuts_b + 8'(flag_b & ~prev_b);
         prev_a <= flag_a;
         prev_b <= flag_b;
      end
   end
endmodule : ovrfd_agc_model
`default_nettype wire

// ### test/adc_overrange_fast_detect_tb.sv
// Self-checking bench for the overrange and fast detect block
`timescale 1ns/1ps
`default_nettype none
module adc_overrange_fast_detect_tb;
   localparam int PL = 4, DLY = PL + 1, UP = 13'hFFF, LO = 13'hA1D;
   logic clock = 0, reset = 1, ovr_a = 0, ovr_b = 0, ctrl = 0;
   logic wr = 0, rd = 0, fa, fb, oa, ob, la, lb;
   logic [12:0] ma = 0, mb = 0, addr = 0;
   logic [7:0] vc = 0, wd = 0, rdata, cuts_a, cuts_b;
   int n_errors = 0, check_count = 0, cycles = 0, st, b, dw, exp_cuts[2];
   ovrfd_top #(.PIPE_LAT(PL)) uut (.clock(clock), .reset(reset),
      .mag_a(ma), .mag_b(mb), .ovr_in_a(ovr_a), .ovr_in_b(ovr_b),
      .vc_ovr(vc), .ctrl_bits_nonzero(ctrl), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
      .threshold_flag_out_a(fa), .threshold_flag_out_b(fb),
      .ovr_out_a(oa), .ovr_out_b(ob), .link_ctrl_a(la), .link_ctrl_b(lb));
   ovrfd_agc_model agc (.clock(clock), .reset(reset), .flag_a(fa),
      .flag_b(fb), .cuts_a(cuts_a), .cuts_b(cuts_b));
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(string what, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk
   task automatic wreg(logic [12:0] a, logic [7:0] d);
      @(posedge clock); #1 {wr, addr, wd} = {1'b1, a, d};
      @(posedge clock); #1 wr = 0;
   endtask : wreg
   task automatic rreg(logic [12:0] a, logic [7:0] e);
      @(posedge clock); #1 {rd, addr} = {1'b1, a};
      @(posedge clock); #1 rd = 0;
      chk("reg", 16'(e), 16'(rdata));
   endtask : rreg
   task automatic pulse(int k);
      @(posedge clock); #1 vc = 8'(1 << k);
      @(posedge clock); #1 vc = 8'h00;
   endtask : pulse
   // Integer model: strict compares, dwell+1 low samples to clear
   function automatic int fd_width(int q[$], int d, output int r);
      int f = 0, c = 0, w = 0, s;
      r = 0;
      if (d == 0) d = 1;
      for (int i = 0; i < q.size() + d + 2; i++) begin
         s = (i < q.size()) ? q[i] : 0;
         if (s > UP) begin
            r += !f;
            f = 1;
            c = 0;
         end else if (f && s < LO) begin
            c++;
            if (c > d) f = 0;
         end else c = 0;
         w += f;
      end
      return w;
   endfunction : fd_width
   task automatic burst(int ch, int q[$]);
      int w = 0, lat = -1, oth = 0, e, r;
      e = fd_width(q, dw, r);
      exp_cuts[ch] += r;
      for (int i = 0; i < q.size() + dw + 40; i++) begin
         @(posedge clock); #1;
         if (ch ? fb : fa) w++;
         if ((ch ? fb : fa) && lat < 0) lat = i;
         if (ch ? fa : fb) oth++;
         {ma, mb} = 0;
         if (i < q.size()) if (ch) mb = 13'(q[i]); else ma = 13'(q[i]);
      end
      chk("width", 16'(e), 16'(w));
      chk("other", 16'h0000, 16'(oth));
      if (e > 0) chk("latency", 1, 16'(lat <= 28));
   endtask : burst
   initial begin
      void'($urandom(32'h5E29D3F5));
      exp_cuts = '{0, 0};
      repeat (2) @(posedge clock);
      #1 reset = 0;
      rreg(13'h024B, 8'h01);
      rreg(13'h0563, 8'h00);
      wreg(13'h1000, 8'hAA);
      rreg(13'h1000, 8'h00);
      wreg(13'h0248, 8'hFF);
      rreg(13'h0248, 8'h1F);
      wreg(13'h0247, 8'hFF);
      wreg(13'h0248, 8'h0F);
      wreg(13'h0249, 8'h1D);
      wreg(13'h024A, 8'h0A);
      rreg(13'h024A, 8'h0A);
      rreg(13'h0247, 8'hFF);
      rreg(13'h0249, 8'h1D);
      wreg(13'h024C, 8'h5A);
      rreg(13'h024C, 8'h5A);
      for (int k = 0; k < 4; k++) begin
         dw = (k == 0) ? 0 : $urandom_range(6, 1);
         wreg(13'h024B, 8'(dw));
         wreg(13'h024C, 8'h00);
         for (int ch = 0; ch < 2; ch++) begin
            burst(ch, '{UP + 1});
            burst(ch, '{UP});
            burst(ch, '{8191, 0, 0, LO, 0});
            burst(ch, '{$urandom_range(8191, 0), $urandom_range(8191, 0),
               $urandom_range(8191, 0), $urandom_range(8191, 0)});
         end
      end
      chk("cuts", 16'(exp_cuts[0]), 16'(cuts_a));
      chk("cuts", 16'(exp_cuts[1]), 16'(cuts_b));
      for (int ph = 0; ph < 2; ph++) begin
         logic [1:0] h[$];
         h.delete();
         ctrl = ph[0];
         for (int i = 0; i < 30; i++) begin
            @(posedge clock); #1;
            if (i >= DLY) chk("ovr", 16'(h[i-DLY]), 16'({ob, oa}));
            if (i >= DLY) chk("link", ph ? 16'(h[i-DLY]) : 0, 16'({lb, la}));
            h.push_back(2'($urandom));
            {ovr_b, ovr_a} = h[i];
         end
      end
      st = 0;
      for (int k = 0; k < 3; k++) begin
         b = $urandom_range(7, 0);
         pulse(b);
         st |= 1 << b;
         rreg(13'h0563, 8'(st));
         wreg(13'h0562, 8'(1 << b));
         rreg(13'h0562, 8'(1 << b));
         st &= ~(1 << b);
         rreg(13'h0563, 8'(st));
         pulse(b);
         rreg(13'h0563, 8'(st));
         wreg(13'h0562, 8'h00);
         pulse(b);
         st |= 1 << b;
         rreg(13'h0563, 8'(st));
      end
      conclude();
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
endmodule : adc_overrange_fast_detect_tb
`default_nettype wire
